/* File: src/dcpwm_consts.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  dual channel modulator.
  Assumes a 200 MHz system clock and APB with one 32-bit word per register.
*/
// What this block does
// - Two outputs share one prescaler and counter
// - 8-bit prescaler divides by reload plus one
// - Shared counter runs 0 to 254, wraps
// - Output low when duty exceeds counter
// - Output high when duty at most counter
// - Period is clock over 2, prescale, 255
// - Duty 00 stays high, FF stays low
// - New duty value acts without waiting period
// - Prescaler read returns reload, not count
// - Both output pins serve only modulation
`ifndef DCPWM_CONSTS_SVH
`define DCPWM_CONSTS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define DCPWM_IDX_DUTY_A 8'hFC
`define DCPWM_IDX_DUTY_B 8'hFD
`define DCPWM_IDX_PRESCALE 8'hFE
`define DCPWM_ADDR_W 12
`define DCPWM_ADDR_DUTY_A {2'h0, `DCPWM_IDX_DUTY_A, 2'h0}
`define DCPWM_ADDR_DUTY_B {2'h0, `DCPWM_IDX_DUTY_B, 2'h0}
`define DCPWM_ADDR_PRESCALE {2'h0, `DCPWM_IDX_PRESCALE, 2'h0}

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DCPWM_FIELD_LSB 0
`define DCPWM_FIELD_MSB 7
`define DCPWM_RST_DUTY 8'h00
`define DCPWM_RST_PRESCALE 8'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define DCPWM_CNT_LAST 8'hFE
`define DCPWM_PRE_STAGE 1'h1

`endif

/* File: src/dcpwm_pkg.sv */
/*
  Types shared by the modulator files.
  Assumes the constants header supplies all numbers.
*/
package dcpwm_pkg;
  typedef logic [7:0] dcpwm_byte_t;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_DUTY_A,
    SEL_DUTY_B,
    SEL_PRESCALE
  } dcpwm_sel_t;
endpackage

/* File: src/dcpwm_time_if.sv */
/*
  Carrier between the register side and the shared time base.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface dcpwm_time_if;
  dcpwm_pkg::dcpwm_byte_t reload;
  dcpwm_pkg::dcpwm_byte_t count;
  modport base (
    input reload,
    output count
  );
  modport user (
    output reload,
    input count
  );
endinterface

/* File: src/dcpwm_timebase.sv */
/*
  Shared time base: divide by two, 8-bit prescaler, modulo 255 counter.
  Assumes a synchronous active high reset on the same clock.
*/
`timescale 1ns/1ps
`include "dcpwm_consts.svh"
module dcpwm_timebase (
  input wire logic clk,
  input wire logic rst,
  dcpwm_time_if.base tb
);
  logic half_reg;
  logic half_next;
  dcpwm_pkg::dcpwm_byte_t pre_reg;
  dcpwm_pkg::dcpwm_byte_t pre_next;
  dcpwm_pkg::dcpwm_byte_t cnt_reg;
  dcpwm_pkg::dcpwm_byte_t cnt_next;
  wire logic pre_expire;

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  // Fixed divide by two ahead of the prescaler
  assign half_next = ~half_reg;
  assign pre_expire = (half_reg == `DCPWM_PRE_STAGE) && (pre_reg == 8'h00);
  // Reload from register on each expiry, so a new reload acts next round
  assign pre_next = ~half_reg ? pre_reg :
                    pre_expire ? tb.reload : pre_reg - 8'h01;
  assign cnt_next = ~pre_expire ? cnt_reg :
                    (cnt_reg == `DCPWM_CNT_LAST) ? 8'h00 : cnt_reg + 8'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      half_reg <= 1'b0;
      pre_reg <= `DCPWM_RST_PRESCALE;
      cnt_reg <= 8'h00;
    end else begin
      half_reg <= half_next;
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end
  end

  assign tb.count = cnt_reg;
endmodule

/* File: src/dcpwm_top.sv */
/*
  Dual channel pulse width modulator with APB register access.
  Assumes an APB master on MCLK and push-pull loads on the two outputs.
*/
`timescale 1ns/1ps
`include "dcpwm_consts.svh"
module dcpwm_top (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`DCPWM_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic MOD_OUT_A_N,
  output logic MOD_OUT_B_N
);
  dcpwm_time_if tb_if ();

  dcpwm_pkg::dcpwm_byte_t duty_compare_a_reg;
  dcpwm_pkg::dcpwm_byte_t duty_compare_b_reg;
  dcpwm_pkg::dcpwm_byte_t prescale_reload_reg;
  logic out_a_reg;
  logic out_b_reg;
  logic ready_reg;
  logic err_reg;
  logic [31:0] rdata_reg;

  wire dcpwm_pkg::dcpwm_sel_t sel;
  wire logic setup;
  wire logic wr_commit;
  wire logic lane0;
  wire dcpwm_pkg::dcpwm_byte_t rd_byte;
  wire logic out_a_next;
  wire logic out_b_next;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic dcpwm_pkg::dcpwm_sel_t decode(input logic [`DCPWM_ADDR_W-1:0] a);
    dcpwm_pkg::dcpwm_sel_t s;
    s = dcpwm_pkg::SEL_NONE;
    if (a == `DCPWM_ADDR_DUTY_A)
      s = dcpwm_pkg::SEL_DUTY_A;
    else if (a == `DCPWM_ADDR_DUTY_B)
      s = dcpwm_pkg::SEL_DUTY_B;
    else if (a == `DCPWM_ADDR_PRESCALE)
      s = dcpwm_pkg::SEL_PRESCALE;
    return s;
  endfunction

  assign sel = decode(PADDR);
  assign setup = PSEL && !PENABLE;
  // Ready comes from a flop, so every access has exactly one wait-free phase
  assign wr_commit = PSEL && PENABLE && ready_reg && PWRITE && !err_reg;
  assign lane0 = PSTRB[0];
  // Prescaler reads give the reload value only
  assign rd_byte = (sel == dcpwm_pkg::SEL_DUTY_A) ? duty_compare_a_reg :
                   (sel == dcpwm_pkg::SEL_DUTY_B) ? duty_compare_b_reg :
                   (sel == dcpwm_pkg::SEL_PRESCALE) ? prescale_reload_reg :
                   8'h00;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ready_reg <= setup;
      err_reg <= setup && (sel == dcpwm_pkg::SEL_NONE);
      if (setup && !PWRITE)
        rdata_reg <= {24'h000000, rd_byte};
      else if (setup)
        rdata_reg <= 32'h00000000;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      duty_compare_a_reg <= `DCPWM_RST_DUTY;
      duty_compare_b_reg <= `DCPWM_RST_DUTY;
      prescale_reload_reg <= `DCPWM_RST_PRESCALE;
    end else if (wr_commit && lane0) begin
      case (sel)
        dcpwm_pkg::SEL_DUTY_A: duty_compare_a_reg <= PWDATA[`DCPWM_FIELD_MSB:`DCPWM_FIELD_LSB];
        dcpwm_pkg::SEL_DUTY_B: duty_compare_b_reg <= PWDATA[`DCPWM_FIELD_MSB:`DCPWM_FIELD_LSB];
        dcpwm_pkg::SEL_PRESCALE: begin
          prescale_reload_reg <= PWDATA[`DCPWM_FIELD_MSB:`DCPWM_FIELD_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Shared time base and compare
  // ----------------------------------------
  assign tb_if.reload = prescale_reload_reg;

  dcpwm_timebase u_timebase (
    .clk(MCLK),
    .rst(SRST),
    .tb(tb_if)
  );

  // Compare on live registers, no period shadow; FF never matches 254 max
  assign out_a_next = !(duty_compare_a_reg > tb_if.count);
  assign out_b_next = !(duty_compare_b_reg > tb_if.count);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      out_a_reg <= 1'b1;
      out_b_reg <= 1'b1;
    end else begin
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Dedicated pins, nothing else muxed in
  assign MOD_OUT_A_N = out_a_reg;
  assign MOD_OUT_B_N = out_b_reg;
  assign PRDATA = rdata_reg;
  assign PREADY = ready_reg;
  assign PSLVERR = err_reg;
endmodule

/* File: verification/dcpwm_assertions.sv */
/* Checker on the dcpwm_top ports, bound at the foot.
   Assumes one MCLK domain and a synchronous SRST. */
`timescale 1ns/1ps
module dcpwm_assertions (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MOD_OUT_A_N,
  input wire logic MOD_OUT_B_N
);
  logic [7:0] a_reg, b_reg, p_reg;
  wire logic wr = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0] & !PSLVERR;
  // Shadows of committed writes, since duties are not visible at the pins
  always_ff @(posedge MCLK) begin
    if (SRST) {a_reg, b_reg, p_reg} <= 24'h000000;
    else if (wr && PADDR == 12'h3F0) a_reg <= PWDATA[7:0];
    else if (wr && PADDR == 12'h3F4) b_reg <= PWDATA[7:0];
    else if (wr && PADDR == 12'h3F8) p_reg <= PWDATA[7:0];
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence answer_s; PENABLE && PREADY ##1 !PREADY; endsequence
  ready_pulse_a: assert property (setup_s |=> answer_s)
    else $error("ready missing");
  read_back_a: assert property (
    PREADY && !PWRITE && PADDR == 12'h3F8 |-> PRDATA[7:0] == p_reg) else $error("bad reload");
  full_low_a: assert property (
    a_reg == 8'hFF && $past(a_reg) == 8'hFF |-> !MOD_OUT_A_N) else $error("A not low");
  full_high_a: assert property (
    a_reg == 8'h00 && $past(a_reg) == 8'h00 |-> MOD_OUT_A_N) else $error("A not high");
  b_low_a: assert property (
    b_reg == 8'hFF && $past(b_reg) == 8'hFF |-> !MOD_OUT_B_N) else $error("B not low");
  fresh_a_a: assert property (
    $changed(a_reg) && a_reg == 8'h00 |=> MOD_OUT_A_N) else $error("A late");
  fresh_b_a: assert property (
    $changed(b_reg) && b_reg == 8'hFF |=> !MOD_OUT_B_N) else $error("B late");
  same_phase_a: assert property (
    a_reg == b_reg && $past(a_reg == b_reg) |-> MOD_OUT_A_N == MOD_OUT_B_N)
    else $error("phase split");
endmodule
bind dcpwm_top dcpwm_assertions chk (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MOD_OUT_A_N(MOD_OUT_A_N),
  .MOD_OUT_B_N(MOD_OUT_B_N));

/* File: verification/dcpwm_load.sv */
/* Load model: integrator counting low cycles of both outputs.
   Assumes outputs change on MCLK. */
`timescale 1ns/1ps
module dcpwm_load (
  input wire logic clk,
  input wire logic clr,
  input wire logic a_n,
  input wire logic b_n,
  output int low_a,
  output int low_b
);
  // Counts per cycle, so one full period gives the exact duty
  always @(posedge clk) begin
    low_a <= clr ? 0 : low_a + int'(a_n === 1'b0);
    low_b <= clr ? 0 : low_b + int'(b_n === 1'b0);
  end
endmodule

/* File: verification/test_dual_channel_pwm.sv */
/* Bench for dcpwm_top with load model.
   Assumes zero-wait APB and a 200 MHz MCLK. */
`timescale 1ns/1ps
module test_dual_channel_pwm;
  logic MCLK = 0;
  logic SRST = 1;
  logic PSEL = 0, PENABLE = 0, PWRITE = 0, clr = 1, er;
  logic PREADY, PSLVERR, MOD_OUT_A_N, MOD_OUT_B_N;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [3:0] PSTRB = 0;
  int n_fail = 0, check_count = 0, low_a, low_b, t_low, t_all;
  typedef struct {logic [11:0] a; logic [31:0] d, e; logic [3:0] s; logic r;} dcpwm_row_t;
  // Address, write data, read back, strobes, error
  dcpwm_row_t rows [6] = '{'{12'h3F0, 32'h1A5, 32'hA5, 4'hF, 1'b0},
    '{12'h3F4, 32'h5A, 32'h5A, 4'hF, 1'b0}, '{12'h3F8, 32'hFF, 32'hFF, 4'hF, 1'b0},
    '{12'h3F8, 32'h11, 32'hFF, 4'h0, 1'b0}, '{12'h3FC, 32'h77, 32'h0, 4'hF, 1'b1},
    '{12'h000, 32'h3C, 32'h0, 4'hF, 1'b1}};
  dcpwm_top uut (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MOD_OUT_A_N(MOD_OUT_A_N), .MOD_OUT_B_N(MOD_OUT_B_N));
  dcpwm_load load (.clk(MCLK), .clr(clr), .a_n(MOD_OUT_A_N), .b_n(MOD_OUT_B_N),
    .low_a(low_a), .low_b(low_b));
  initial forever #2.5 MCLK = ~MCLK;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n = 0;
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} <= {2'b10, w, a, d, s};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1 && ++n < 20);
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
    if (n >= 20) begin
      n_fail++;
      print_verdict;
    end
  endtask
  // A full count over a whole period hides the divider, so time the runs
  task automatic measure_a(output int lo, output int all);
    int k = 0;
    lo = 0;
    all = 0;
    while (MOD_OUT_A_N !== 1'b1 && k < 3000) begin
      @(posedge MCLK);
      k++;
    end
    while (MOD_OUT_A_N !== 1'b0 && k < 3000) begin
      @(posedge MCLK);
      k++;
    end
    while (MOD_OUT_A_N === 1'b0 && k < 3000) begin
      @(posedge MCLK);
      k++;
      lo++;
    end
    while (MOD_OUT_A_N === 1'b1 && k < 3000) begin
      @(posedge MCLK);
      k++;
      all++;
    end
    all = all + lo;
    if (k >= 3000) begin
      n_fail++;
      print_verdict;
    end
  endtask
  initial begin
    repeat (6) @(posedge MCLK);
    SRST <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      apb(1'b0, rows[i].a, 32'h0, 4'hF);
      chk(rd, rows[i].e);
      chk(er, rows[i].r);
    end
    $display("register rows done");
    apb(1'b1, 12'h3F8, 32'h1, 4'hF);
    apb(1'b1, 12'h3F0, 32'h80, 4'hF);
    apb(1'b1, 12'h3F4, 32'hFF, 4'hF);
    // New reload lands only at the next expiry, so settle first
    repeat (1100) @(posedge MCLK);
    clr <= 1'b0;
    repeat (1021) @(posedge MCLK);
    chk(low_a, 32'h200);
    chk(low_b, 32'h3FC);
    // Ends just after A falls, so the updates below land early in a low run
    measure_a(t_low, t_all);
    chk(t_low, 32'h200);
    chk(t_all, 32'h3FC);
    $display("duty period done");
    apb(1'b1, 12'h3F0, 32'h0, 4'hF);
    repeat (2) @(posedge MCLK);
    chk(MOD_OUT_A_N, 1'b1);
    apb(1'b1, 12'h3F0, 32'hFF, 4'hF);
    repeat (2) @(posedge MCLK);
    chk(MOD_OUT_A_N, 1'b0);
    $display("update done");
    SRST <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk({PREADY, PSLVERR, MOD_OUT_A_N, MOD_OUT_B_N}, 4'h3);
    SRST <= 1'b0;
    apb(1'b0, 12'h3F8, 32'h0, 4'hF);
    chk(rd, 32'h0);
    chk({MOD_OUT_A_N, MOD_OUT_B_N}, 2'b11);
    $display("reset done");
    print_verdict;
  end
endmodule
